// ==== rtl/dsp_multiply_accumulate_prefetch.sv ====
// Purpose: Multiply, multiply-accumulate and prefetch datapath
// Assumes: X and Y memories answer combinationally from the held address
// Notes:   Each command takes two cycles: accept, then execute
`timescale 1ns/10ps
module dsp_multiply_accumulate_prefetch #(
  parameter int ACC_W = 40
) (
  input  wire logic                                  clock,
  input  wire logic                                  reset,
  input  wire logic                                  cmd_valid,
  input  wire mac_prefetch_pkg::mac_cmd_s            cmd,
  output logic                                       cmd_ready,
  input  wire logic                                  ptr_load_en,
  input  wire logic                                  ptr_load_y,
  input  wire logic                                  ptr_load_sel,
  input  wire logic [mac_prefetch_pkg::WORD_W-1:0]   ptr_load_data,
  output logic                                       x_rd_en,
  output logic [mac_prefetch_pkg::WORD_W-1:0]        x_addr,
  input  wire logic [mac_prefetch_pkg::WORD_W-1:0]   x_rd_data,
  output logic                                       y_rd_en,
  output logic [mac_prefetch_pkg::WORD_W-1:0]        y_addr,
  input  wire logic [mac_prefetch_pkg::WORD_W-1:0]   y_rd_data,
  output logic [ACC_W-1:0]                           acc_a,
  output logic [ACC_W-1:0]                           acc_b,
  output logic [mac_prefetch_pkg::NUM_OPND-1:0]
               [mac_prefetch_pkg::WORD_W-1:0]        opnd_regs,
  output logic                                       done,
  output logic                                       wb_valid,
  output logic [mac_prefetch_pkg::REG_ID_W-1:0]      acc_writeback_dest,
  output logic [mac_prefetch_pkg::WORD_W-1:0]        wb_data,
  output logic                                       int_valid,
  output logic [mac_prefetch_pkg::REG_ID_W-1:0]      int_dest,
  output logic [mac_prefetch_pkg::INT_W-1:0]         int_product
);
  localparam int W = mac_prefetch_pkg::WORD_W;
  localparam int PW = mac_prefetch_pkg::PROD_W;
  localparam int NO = mac_prefetch_pkg::NUM_OPND;
  localparam int NP = mac_prefetch_pkg::NUM_PTR;

  // The accumulator must hold the sign-extended product and the
  // write-back slice; a narrower build would silently drop high bits
  if (ACC_W < PW) begin : g_acc_too_narrow
    $error("ACC_W narrower than the product");
  end
  if (ACC_W < mac_prefetch_pkg::WB_LSB + W) begin : g_wb_out_of_range
    $error("ACC_W too narrow for the write-back slice");
  end

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_exec = 2'b10
  } mac_state_e;

  mac_state_e                 state_reg, state_next;
  mac_prefetch_pkg::mac_cmd_s cmd_reg, cmd_next;
  logic [ACC_W-1:0]           acc_a_reg, acc_a_next;
  logic [ACC_W-1:0]           acc_b_reg, acc_b_next;
  logic [NO-1:0][W-1:0]       opnd_reg, opnd_next;
  logic [NP-1:0][W-1:0]       xptr_reg, xptr_next;
  logic [NP-1:0][W-1:0]       yptr_reg, yptr_next;
  logic                       x_rd_en_reg, x_rd_en_next;
  logic [W-1:0]               x_addr_reg, x_addr_next;
  logic                       y_rd_en_reg, y_rd_en_next;
  logic [W-1:0]               y_addr_reg, y_addr_next;
  logic                       done_reg, done_next;
  logic                       wb_valid_reg, wb_valid_next;
  logic [mac_prefetch_pkg::REG_ID_W-1:0] wb_dest_reg, wb_dest_next;
  logic [W-1:0]               wb_data_reg, wb_data_next;
  logic                       int_valid_reg, int_valid_next;
  logic [mac_prefetch_pkg::REG_ID_W-1:0] int_dest_reg, int_dest_next;
  logic [mac_prefetch_pkg::INT_W-1:0]    int_prod_reg, int_prod_next;
  logic                       ready_reg, ready_next;

  logic                       accept;
  logic signed [W:0]          mul_a, mul_b;
  logic signed [PW-1:0]       product;
  logic [ACC_W-1:0]           prod_ext;
  logic [ACC_W-1:0]           acc_target;
  logic [ACC_W-1:0]           acc_result;
  logic [W-1:0]               second_op;
  logic                       a_signed, b_signed;

  // Commands offered during execute are refused, not queued
  assign accept = cmd_valid && (state_reg == st_idle);

  // Operand shaping; sign extension selects the integer sign mode
  always_comb begin
    // The immediate is zero-extended, so only unsigned second operands use it
    second_op = cmd.int_b;
    if (cmd.int_imm_en &&
        (cmd.int_mode == mac_prefetch_pkg::int_mul_signed_unsigned ||
         cmd.int_mode == mac_prefetch_pkg::int_mul_unsigned_unsigned)) begin
      second_op = W'(cmd.int_imm);
    end
    a_signed = 1'b1;
    b_signed = 1'b1;
    unique case (cmd.int_mode)
      mac_prefetch_pkg::int_mul_signed_signed: begin
        a_signed = 1'b1;
        b_signed = 1'b1;
      end
      mac_prefetch_pkg::int_mul_signed_unsigned: begin
        a_signed = 1'b1;
        b_signed = 1'b0;
      end
      mac_prefetch_pkg::int_mul_unsigned_signed: begin
        a_signed = 1'b0;
        b_signed = 1'b1;
      end
      mac_prefetch_pkg::int_mul_unsigned_unsigned: begin
        a_signed = 1'b0;
        b_signed = 1'b0;
      end
    endcase
    if (cmd.op == mac_prefetch_pkg::op_intmul) begin
      mul_a = {a_signed & cmd.int_a[W-1], cmd.int_a};
      mul_b = {b_signed & second_op[W-1], second_op};
    end else begin
      mul_a = {opnd_reg[cmd.mul_a_sel][W-1], opnd_reg[cmd.mul_a_sel]};
      mul_b = {opnd_reg[cmd.mul_b_sel][W-1], opnd_reg[cmd.mul_b_sel]};
    end
  end

  // Operands enter the multiplier at accept, so execute needs no second stage
  mac_mult17 u_mult (
    .clock   (clock),
    .reset   (reset),
    .enable  (accept),
    .a       (mul_a),
    .b       (mul_b),
    .product (product)
  );

  // The size cast of a signed product carries the sign to the guard bits
  assign prod_ext = ACC_W'(product);
  assign acc_target = cmd_reg.acc_sel ? acc_b_reg : acc_a_reg;

  // Arithmetic on the targeted accumulator during execute
  always_comb begin
    acc_result = acc_target;
    unique case (cmd_reg.op)
      mac_prefetch_pkg::op_mpy:    acc_result = prod_ext;
      mac_prefetch_pkg::op_mpyn:   acc_result = -prod_ext;
      mac_prefetch_pkg::op_msc:    acc_result = acc_target - prod_ext;
      mac_prefetch_pkg::op_movsac: acc_result = acc_target;
      // Undefined op codes leave the target accumulator as it was
      default:                     acc_result = acc_target;
    endcase
  end

  // Control and datapath next state
  always_comb begin
    state_next     = state_reg;
    cmd_next       = cmd_reg;
    acc_a_next     = acc_a_reg;
    acc_b_next     = acc_b_reg;
    opnd_next      = opnd_reg;
    xptr_next      = xptr_reg;
    yptr_next      = yptr_reg;
    x_rd_en_next   = 1'b0;
    x_addr_next    = x_addr_reg;
    y_rd_en_next   = 1'b0;
    y_addr_next    = y_addr_reg;
    done_next      = 1'b0;
    wb_valid_next  = 1'b0;
    wb_dest_next   = wb_dest_reg;
    wb_data_next   = wb_data_reg;
    int_valid_next = 1'b0;
    int_dest_next  = int_dest_reg;
    int_prod_next  = int_prod_reg;
    // A same-cycle prefetch advance below overrides this load
    if (ptr_load_en) begin
      if (ptr_load_y) begin
        yptr_next[ptr_load_sel] = ptr_load_data;
      end else begin
        xptr_next[ptr_load_sel] = ptr_load_data;
      end
    end
    unique case (state_reg)
      st_idle: begin
        if (accept) begin
          state_next = st_exec;
          cmd_next   = cmd;
          if (cmd.op != mac_prefetch_pkg::op_intmul && cmd.x_pf.en) begin
            x_rd_en_next = 1'b1;
            x_addr_next  = xptr_reg[cmd.x_pf.ptr_sel];
            xptr_next[cmd.x_pf.ptr_sel] = xptr_reg[cmd.x_pf.ptr_sel]
                + mac_prefetch_pkg::step_value(cmd.x_pf);
          end
          if (cmd.op != mac_prefetch_pkg::op_intmul && cmd.y_pf.en) begin
            y_rd_en_next = 1'b1;
            y_addr_next  = yptr_reg[cmd.y_pf.ptr_sel];
            yptr_next[cmd.y_pf.ptr_sel] = yptr_reg[cmd.y_pf.ptr_sel]
                + mac_prefetch_pkg::step_value(cmd.y_pf);
          end
        end
      end
      st_exec: begin
        state_next = st_idle;
        done_next  = 1'b1;
        // Integer results bypass the accumulators entirely
        if (cmd_reg.op == mac_prefetch_pkg::op_intmul) begin
          int_valid_next = 1'b1;
          int_dest_next  = cmd_reg.int_dest;
          int_prod_next  = product[mac_prefetch_pkg::INT_W-1:0];
        end else begin
          if (cmd_reg.acc_sel) begin
            acc_b_next = acc_result;
          end else begin
            acc_a_next = acc_result;
          end
          // Y is written last, so it wins when both name one register
          if (x_rd_en_reg) begin
            opnd_next[cmd_reg.x_pf.dest] = x_rd_data;
          end
          if (y_rd_en_reg) begin
            opnd_next[cmd_reg.y_pf.dest] = y_rd_data;
          end
          if (cmd_reg.wb_en &&
              (cmd_reg.op == mac_prefetch_pkg::op_msc ||
               cmd_reg.op == mac_prefetch_pkg::op_movsac)) begin
            // Only the untargeted accumulator is read, so no update races it
            wb_valid_next = 1'b1;
            wb_dest_next  = cmd_reg.acc_writeback_dest;
            wb_data_next  = cmd_reg.acc_sel
                ? acc_a_reg[mac_prefetch_pkg::WB_LSB +: W]
                : acc_b_reg[mac_prefetch_pkg::WB_LSB +: W];
          end
        end
      end
    endcase
    // Ready leaves a flop so the decoder sees no decode logic on it
    ready_next = state_next == st_idle;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg     <= st_idle;
      cmd_reg       <= '0;
      acc_a_reg     <= '0;
      acc_b_reg     <= '0;
      opnd_reg      <= '0;
      xptr_reg      <= '0;
      yptr_reg      <= '0;
      x_rd_en_reg   <= 1'b0;
      x_addr_reg    <= '0;
      y_rd_en_reg   <= 1'b0;
      y_addr_reg    <= '0;
      done_reg      <= 1'b0;
      wb_valid_reg  <= 1'b0;
      wb_dest_reg   <= '0;
      wb_data_reg   <= '0;
      int_valid_reg <= 1'b0;
      int_dest_reg  <= '0;
      int_prod_reg  <= '0;
      ready_reg     <= 1'b1;
    end else begin
      state_reg     <= state_next;
      cmd_reg       <= cmd_next;
      acc_a_reg     <= acc_a_next;
      acc_b_reg     <= acc_b_next;
      opnd_reg      <= opnd_next;
      xptr_reg      <= xptr_next;
      yptr_reg      <= yptr_next;
      x_rd_en_reg   <= x_rd_en_next;
      x_addr_reg    <= x_addr_next;
      y_rd_en_reg   <= y_rd_en_next;
      y_addr_reg    <= y_addr_next;
      done_reg      <= done_next;
      wb_valid_reg  <= wb_valid_next;
      wb_dest_reg   <= wb_dest_next;
      wb_data_reg   <= wb_data_next;
      int_valid_reg <= int_valid_next;
      int_dest_reg  <= int_dest_next;
      int_prod_reg  <= int_prod_next;
      ready_reg     <= ready_next;
    end
  end

  // A command is only taken from idle; ready mirrors that from a flop
  assign cmd_ready          = ready_reg;
  assign x_rd_en            = x_rd_en_reg;
  assign x_addr             = x_addr_reg;
  assign y_rd_en            = y_rd_en_reg;
  assign y_addr             = y_addr_reg;
  assign acc_a              = acc_a_reg;
  assign acc_b              = acc_b_reg;
  assign opnd_regs          = opnd_reg;
  assign done               = done_reg;
  assign wb_valid           = wb_valid_reg;
  assign acc_writeback_dest = wb_dest_reg;
  assign wb_data            = wb_data_reg;
  assign int_valid          = int_valid_reg;
  assign int_dest           = int_dest_reg;
  assign int_product        = int_prod_reg;
endmodule : dsp_multiply_accumulate_prefetch

// ==== rtl/mac_mult17.sv ====
// Purpose: Registered 17 by 17 signed multiplier shared by every operation
// Assumes: Callers extend 16-bit operands with the sign rule they need
// Notes:   One cycle latency; product holds until the next enable
`timescale 1ns/10ps
module mac_mult17 (
  input  wire logic                                 clock,
  input  wire logic                                 reset,
  input  wire logic                                 enable,
  input  wire logic signed [mac_prefetch_pkg::WORD_W:0] a,
  input  wire logic signed [mac_prefetch_pkg::WORD_W:0] b,
  output logic signed [mac_prefetch_pkg::PROD_W-1:0]    product
);
  logic signed [mac_prefetch_pkg::PROD_W-1:0] product_next;

  always_comb begin
    product_next = product;
    if (enable) begin
      product_next = a * b;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      product <= '0;
    end else begin
      product <= product_next;
    end
  end
endmodule : mac_mult17

// ==== rtl/mac_prefetch_pkg.sv ====
// Purpose: Shared constants and command layout for the multiply datapath
// Assumes: One core clock; the decoder holds a command until it is taken
// Notes:   Operation and sign modes are one-hot free binary codes
// Summary of operation
// - Multiply loads product into selected accumulator
// - Negated multiply loads minus product
// - Multiply-subtract removes product from accumulator
// - No X prefetch: no read, nothing changes
// - No Y prefetch: no read, nothing changes
// - Step is -6..6 by two, or register
// - Performed prefetch advances its pointer
// - Prefetched word lands in named destination
// - X reads X memory, Y reads Y
// - Write-back stores the other accumulator
// - Prefetch-only leaves accumulators arithmetically alone
// - Signed by signed gives signed product
// - Mixed-sign multiplies follow opcode sign choice
// - Unsigned by unsigned gives unsigned product
// - Two multiplies accept immediate second operand
package mac_prefetch_pkg;

  localparam int WORD_W    = 16;
  localparam int LIT_W     = 5;
  localparam int PROD_W    = 34;
  localparam int INT_W     = 32;
  localparam int NUM_OPND  = 4;
  localparam int NUM_PTR   = 2;
  localparam int REG_ID_W  = 4;
  // Write-back takes the accumulator word just above the low product word
  localparam int WB_LSB    = 16;

  typedef enum logic [2:0] {
    op_mpy    = 3'h0,
    op_mpyn   = 3'h1,
    op_msc    = 3'h2,
    op_movsac = 3'h3,
    op_intmul = 3'h4
  } mac_op_e;

  typedef enum logic [1:0] {
    int_mul_signed_signed     = 2'h0,
    int_mul_signed_unsigned   = 2'h1,
    int_mul_unsigned_signed   = 2'h2,
    int_mul_unsigned_unsigned = 2'h3
  } int_mode_e;

  // Step codes 0..6 map to -6..+6 bytes; code 7 takes the register value
  localparam logic [2:0] INCR_FROM_REG = 3'h7;
  localparam logic [2:0] INCR_ZERO     = 3'h3;

  typedef struct packed {
    logic                 en;
    logic                 ptr_sel;
    logic [2:0]           incr_code;
    logic [WORD_W-1:0]    incr_reg;
    logic [1:0]           dest;
  } prefetch_s;

  typedef struct packed {
    mac_op_e              op;
    int_mode_e            int_mode;
    logic                 acc_sel;
    logic [1:0]           mul_a_sel;
    logic [1:0]           mul_b_sel;
    prefetch_s            x_pf;
    prefetch_s            y_pf;
    logic                 wb_en;
    logic [REG_ID_W-1:0]  acc_writeback_dest;
    logic [WORD_W-1:0]    int_a;
    logic [WORD_W-1:0]    int_b;
    logic                 int_imm_en;
    logic [LIT_W-1:0]     int_imm;
    logic [REG_ID_W-1:0]  int_dest;
  } mac_cmd_s;

  function automatic logic [WORD_W-1:0] step_value(input prefetch_s pf);
    logic [WORD_W-1:0] two_x;
    two_x = WORD_W'({pf.incr_code, 1'b0});
    if (pf.incr_code == INCR_FROM_REG)
      step_value = pf.incr_reg;
    else
      step_value = two_x - WORD_W'({INCR_ZERO, 1'b0});
  endfunction : step_value

endpackage : mac_prefetch_pkg

// ==== verification/dsp_multiply_accumulate_prefetch_test.sv ====
// Purpose: Self-checking bench for the multiply datapath
// Assumes: Memory words are address xor a per-bank key
// Notes:   Back-to-back offers also exercise the refused execute cycle
`timescale 1ns/10ps
module dsp_multiply_accumulate_prefetch_test;
  typedef struct {
    logic [39:0] a0;
    logic [39:0] a1;
    logic [63:0] op;
    logic        wb;
    logic [19:0] wbd;
    logic        iv;
    logic [35:0] ip;
  } exp_s;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  mac_prefetch_pkg::mac_cmd_s cmd = '0;
  logic ld_en = 1'b0;
  logic ld_y = 1'b0;
  logic ld_sel = 1'b0;
  logic [15:0] ld_data = 16'h0000;
  logic rdy, xen, yen, done, wbv, ivld;
  logic [15:0] xa, xd, ya, yd, wbd;
  logic [39:0] acc_a, acc_b;
  logic [3:0][15:0] opnd, m_op, m_ptr;
  logic [1:0][39:0] m_acc;
  logic [3:0] wdst, idst;
  logic [31:0] ip;
  int n_fail = 0;
  int check_count = 0;
  int seed = 32'hfa1febba;
  exp_s q[$];
  exp_s e;

  dsp_multiply_accumulate_prefetch #(.ACC_W(40)) u_dut (.clock, .reset,
    .cmd_valid, .cmd, .cmd_ready(rdy), .ptr_load_en(ld_en),
    .ptr_load_y(ld_y), .ptr_load_sel(ld_sel), .ptr_load_data(ld_data),
    .x_rd_en(xen), .x_addr(xa), .x_rd_data(xd), .y_rd_en(yen),
    .y_addr(ya), .y_rd_data(yd), .acc_a, .acc_b, .opnd_regs(opnd), .done,
    .wb_valid(wbv), .acc_writeback_dest(wdst), .wb_data(wbd),
    .int_valid(ivld), .int_dest(idst), .int_product(ip));
  xy_memory_model u_mem (.clock, .x_rd_en(xen), .x_addr(xa),
    .x_rd_data(xd), .y_rd_en(yen), .y_addr(ya), .y_rd_data(yd));

  always #4 clock = ~clock;

  task automatic check(input string nm, input logic [63:0] x,
                       input logic [63:0] g);
    check_count++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : check

  task automatic summarize();
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  always @(negedge clock) begin
    if (done === 1'b1) begin
      e = q.pop_front();
      check("acc_a", e.a0, acc_a);
      check("acc_b", e.a1, acc_b);
      check("opnd_regs", e.op, opnd);
      check("wb_valid", e.wb, wbv);
      if (e.wb) check("wb", e.wbd, {wdst, wbd});
      check("int_valid", e.iv, ivld);
      if (e.iv) check("int", e.ip, {idst, ip});
    end
  end

  function automatic logic [39:0] sx(input logic [15:0] v);
    sx = {{24{v[15]}}, v};
  endfunction : sx

  task automatic pf(input logic bank, input mac_prefetch_pkg::prefetch_s p);
    logic [1:0] k;
    k = {bank, p.ptr_sel};
    if (p.en) begin
      m_op[p.dest] = m_ptr[k] ^ (bank ? 16'h3C5A : 16'hA5C3);
      if (p.incr_code == mac_prefetch_pkg::INCR_FROM_REG)
        m_ptr[k] = m_ptr[k] + p.incr_reg;
      else
        m_ptr[k] = m_ptr[k] + {p.incr_code, 1'b0} - 16'h0006;
    end
  endtask : pf

  task automatic issue(input mac_prefetch_pkg::mac_cmd_s c);
    logic [39:0] p;
    logic [31:0] ia;
    logic [31:0] ib;
    exp_s x;
    int n;
    p = sx(m_op[c.mul_a_sel]) * sx(m_op[c.mul_b_sel]);
    x.wb = c.wb_en && c.op inside {mac_prefetch_pkg::op_msc,
                                   mac_prefetch_pkg::op_movsac};
    x.wbd = {c.acc_writeback_dest, m_acc[!c.acc_sel][31:16]};
    x.iv = c.op == mac_prefetch_pkg::op_intmul;
    ia = {{16{!c.int_mode[1] && c.int_a[15]}}, c.int_a};
    ib = {{16{!c.int_mode[0] && c.int_b[15]}}, c.int_b};
    if (c.int_imm_en && c.int_mode[0])
      ib = {27'h0000000, c.int_imm};
    x.ip = {c.int_dest, ia * ib};
    case (c.op)
      mac_prefetch_pkg::op_mpy: m_acc[c.acc_sel] = p;
      mac_prefetch_pkg::op_mpyn: m_acc[c.acc_sel] = -p;
      mac_prefetch_pkg::op_msc: m_acc[c.acc_sel] -= p;
      default: ;
    endcase
    if (!x.iv) begin
      pf(1'b0, c.x_pf);
      pf(1'b1, c.y_pf);
    end
    x.a0 = m_acc[0];
    x.a1 = m_acc[1];
    x.op = m_op;
    q.push_back(x);
    cmd = c;
    cmd_valid = 1'b1;
    for (n = 0; n < 8 && rdy !== 1'b1; n++) @(posedge clock) #1;
    if (n == 8) begin
      n_fail++;
      summarize();
    end
    @(posedge clock) #1;
  endtask : issue

  task automatic idle();
    cmd_valid = 1'b0;
    for (int n = 0; n < 12 && q.size() > 0; n++) @(posedge clock) #1;
    check("drained", 0, q.size());
    if (q.size() > 0) summarize();
  endtask : idle

  task automatic do_reset();
    reset = 1'b1;
    repeat (10) @(posedge clock) #1;
    reset = 1'b0;
    {m_acc, m_op, m_ptr} = '0;
    check("cmd_ready", 1, rdy);
    check("acc_a", 0, acc_a);
  endtask : do_reset

  task automatic load_ptrs();
    for (int i = 0; i < 4; i++) begin
      ld_en = 1'b1;
      {ld_y, ld_sel} = 2'(i);
      ld_data = 16'($random(seed)) & 16'hFFFE;
      m_ptr[i] = ld_data;
      @(posedge clock) #1;
    end
    ld_en = 1'b0;
  endtask : load_ptrs

  initial begin
    mac_prefetch_pkg::mac_cmd_s c;
    logic [127:0] r;
    do_reset();
    load_ptrs();
    for (int i = 0; i < 120; i++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed)};
      c = r[$bits(c)-1:0];
      // Code 5 is undecoded: prefetch runs, no accumulator changes
      c.op = mac_prefetch_pkg::mac_op_e'(i % 6);
      c.int_mode = mac_prefetch_pkg::int_mode_e'(i / 6 % 4);
      c.x_pf.incr_code = 3'(i);
      c.y_pf.incr_code = 3'(i + 3);
      if (i < 24) begin
        c.int_a = 16'h8000;
        c.int_b = 16'hFFFF;
      end
      issue(c);
      if (i % 30 == 29) begin
        idle();
        if (i == 59) do_reset();
        load_ptrs();
      end
    end
    idle();
    summarize();
  end
endmodule : dsp_multiply_accumulate_prefetch_test

// ==== verification/mac_prefetch_assertions.sv ====
// Purpose: Port-level timing and result checks for the multiply datapath
// Assumes: Accept edge, one execute cycle, results in the cycle after
// Notes:   Products are sampled at accept, before prefetch overwrites
`timescale 1ns/10ps
module mac_prefetch_checker #(
  parameter int ACC_W = 40
) (
  input wire logic                                  clock,
  input wire logic                                  reset,
  input wire logic                                  cmd_valid,
  input wire mac_prefetch_pkg::mac_cmd_s            cmd,
  input wire logic                                  cmd_ready,
  input wire logic                                  x_rd_en,
  input wire logic                                  y_rd_en,
  input wire logic [ACC_W-1:0]                      acc_a,
  input wire logic [ACC_W-1:0]                      acc_b,
  input wire logic [mac_prefetch_pkg::NUM_OPND-1:0]
                   [mac_prefetch_pkg::WORD_W-1:0]   opnd_regs,
  input wire logic                                  done,
  input wire logic                                  wb_valid,
  input wire logic                                  int_valid,
  input wire logic [mac_prefetch_pkg::INT_W-1:0]    int_product
);
  logic                    take;
  logic                    is_int;
  logic                    is_wb;
  logic [31:0]             uu_prod;
  logic signed [ACC_W-1:0] prod_ext;
  assign take = cmd_valid && cmd_ready;
  assign is_int = cmd.op == mac_prefetch_pkg::op_intmul;
  assign is_wb = cmd.wb_en && (cmd.op == mac_prefetch_pkg::op_msc ||
                 cmd.op == mac_prefetch_pkg::op_movsac);
  assign uu_prod = {16'h0000, cmd.int_a} * {16'h0000, cmd.int_b};
  // Widened before the multiply so the sign reaches the top bits
  assign prod_ext = $signed(opnd_regs[cmd.mul_a_sel]) *
                    $signed(opnd_regs[cmd.mul_b_sel]);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  done_timing_a: assert property (take |=> !done ##1 done)
    else $error("done not two cycles after accept");
  x_skip_a: assert property ((take && (!cmd.x_pf.en || is_int)) |=>
    !x_rd_en ##1 !x_rd_en) else $error("x read without x prefetch");
  y_skip_a: assert property ((take && (!cmd.y_pf.en || is_int)) |=>
    !y_rd_en ##1 !y_rd_en) else $error("y read without y prefetch");
  both_reads_a: assert property (take && cmd.x_pf.en && cmd.y_pf.en
    && !is_int |=> x_rd_en && y_rd_en) else $error("reads not together");
  wb_pulse_a: assert property (take |-> ##2 wb_valid == $past(is_wb, 2))
    else $error("write-back pulse wrong");
  int_pulse_a: assert property (take |-> ##2 int_valid == $past(is_int, 2))
    else $error("integer result pulse wrong");
  acc_hold_a: assert property ((take && (is_int ||
    cmd.op == mac_prefetch_pkg::op_movsac)) |=> $stable(acc_a) &&
    $stable(acc_b) [*2]) else $error("accumulator changed");
  mpy_load_a: assert property ((take && !cmd.acc_sel &&
    cmd.op == mac_prefetch_pkg::op_mpy) |-> ##2 acc_a == $past(prod_ext, 2))
    else $error("multiply result wrong");
  mpyn_load_a: assert property ((take && cmd.acc_sel &&
    cmd.op == mac_prefetch_pkg::op_mpyn) |-> ##2
    acc_b == -$past(prod_ext, 2)) else $error("negated multiply wrong");
  msc_sub_a: assert property ((take && !cmd.acc_sel &&
    cmd.op == mac_prefetch_pkg::op_msc) |-> ##2
    acc_a == $past(acc_a, 2) - $past(prod_ext, 2))
    else $error("multiply-subtract wrong");
  uu_prod_a: assert property ((take && is_int && !cmd.int_imm_en &&
    cmd.int_mode == mac_prefetch_pkg::int_mul_unsigned_unsigned) |-> ##2
    int_product == $past(uu_prod, 2)) else $error("unsigned product wrong");

  cover property (take && is_wb);
  cover property (take && is_int && cmd.int_imm_en);
  cover property (take ##1 cmd_valid && !cmd_ready);
endmodule : mac_prefetch_checker

bind dsp_multiply_accumulate_prefetch mac_prefetch_checker #(.ACC_W(ACC_W))
  u_checker (.clock, .reset, .cmd_valid, .cmd, .cmd_ready, .x_rd_en,
  .y_rd_en, .acc_a, .acc_b, .opnd_regs, .done, .wb_valid, .int_valid,
  .int_product);

// ==== verification/xy_memory_model.sv ====
// Purpose: X and Y data memory model facing the multiply datapath
// Assumes: Each word is its address xor a per-bank key
// Notes:   Outside a read the data toggles so stale values never match
`timescale 1ns/10ps
module xy_memory_model (
  input  wire logic        clock,
  input  wire logic        x_rd_en,
  input  wire logic [15:0] x_addr,
  output logic      [15:0] x_rd_data,
  input  wire logic        y_rd_en,
  input  wire logic [15:0] y_addr,
  output logic      [15:0] y_rd_data
);
  logic [15:0] x_last = 16'h0000;
  logic [15:0] y_last = 16'h0000;
  // Two separate banks, so both reads are served in one cycle
  assign x_rd_data = x_rd_en ? (x_addr ^ 16'hA5C3) : ~x_last;
  assign y_rd_data = y_rd_en ? (y_addr ^ 16'h3C5A) : ~y_last;
  always @(posedge clock) begin
    x_last <= x_rd_data;
    y_last <= y_rd_data;
  end
endmodule : xy_memory_model
